/* File: hdl/class_d_ctrl.sv */
// mode decode, switching clock, modulator and fault sequencing
//
// Local design decisions: strobed register access and the address map.
`timescale 1ns/1ns

module class_d_ctrl #(
  parameter bit FAST_VARIANT = 1'b0,
  parameter int STARTUP_CYCLES = class_d_pkg::STARTUP_CYC,
  parameter int STARTUP_FAST_CYCLES = class_d_pkg::STARTUP_FAST_CYC
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic power_down_n,
  input wire logic sync_level,
  input wire logic sync_floating,
  input wire logic serial_clk_level,
  input wire logic slave_id_strap_0,
  input wire logic slave_id_strap_1,
  input wire logic mute,
  input wire logic [5:0] vol_analog,
  input wire logic signed [7:0] audio_in,
  input wire class_d_pkg::fault_t faults,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output class_d_pkg::drive_t amp_drive,
  output logic cascade_clock_out,
  output logic [5:0] volume_level,
  output logic serial_enable,
  output logic [6:0] slave_addr
);
  localparam int START_N = FAST_VARIANT ? STARTUP_FAST_CYCLES : STARTUP_CYCLES;
  localparam int CNT_W = $clog2(START_N + 1);
  localparam logic [CNT_W-1:0] START_LAST = CNT_W'(START_N - 1);

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  class_d_pkg::sync_mode_t sync_mode_q;
  class_d_pkg::amp_state_t state_q;
  logic sync_prev_q, sync_rise, ext_ok_q, osc_edge, sw_tick, clip_q;
  logic pwm_q, classic, p_on, n_on;
  logic [6:0] win_q;
  logic [4:0] edges_q;
  logic [15:0] nco_q, inc_q, lfsr_q;
  logic [16:0] nco_sum;
  logic [8:0] ss_off, width, half, pc;
  logic [1:0] div_q;
  logic [7:0] pcnt_q, per_q, mag;
  logic [CNT_W-1:0] start_cnt_q;
  logic [5:0] vol_q;
  logic [2:0] since_q;

  // straps both low turn the serial port off; analog volume instead
  assign serial_enable = slave_id_strap_0 | slave_id_strap_1;
  assign slave_addr = {class_d_pkg::SLAVE_BASE, slave_id_strap_1,
                       slave_id_strap_0};
  assign sync_rise = sync_level & ~sync_prev_q;
  // sync pin classification over a fixed window
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sync_prev_q <= 1'b0;
      win_q <= 7'h00;
      edges_q <= 5'h00;
      sync_mode_q <= class_d_pkg::SYNC_LOW;
      ext_ok_q <= 1'b0;
    end else begin
      sync_prev_q <= sync_level;
      if (win_q == 7'(class_d_pkg::EXT_WIN_CYC - 1)) begin
        win_q <= 7'h00;
        // a rise on the closing cycle opens the next count, never lost
        edges_q <= {4'h0, sync_rise};
        // two edges already means toggling; a stuck level gives none
        if (edges_q >= class_d_pkg::TOGGLE_EDGES) begin
          sync_mode_q <= class_d_pkg::SYNC_CLOCKED;
        end else if (sync_floating) begin
          sync_mode_q <= class_d_pkg::SYNC_FLOAT;
        end else if (sync_level) begin
          sync_mode_q <= class_d_pkg::SYNC_HIGH;
        end else begin
          sync_mode_q <= class_d_pkg::SYNC_LOW;
        end
        ext_ok_q <= (edges_q >= class_d_pkg::EDGES_MIN) &&
                    (edges_q <= class_d_pkg::EDGES_MAX);
      end else begin
        win_q <= win_q + 7'h01;
        if (sync_rise && edges_q != 5'h1f) begin
          edges_q <= edges_q + 5'h01;
        end
      end
    end
  end

  // internal oscillator as a phase accumulator
  assign nco_sum = {1'b0, nco_q} + {1'b0, inc_q};
  assign osc_edge = (sync_mode_q == class_d_pkg::SYNC_CLOCKED) ?
                    sync_rise : nco_sum[16];
  assign ss_off = (lfsr_q[8:0] > 9'(2 * class_d_pkg::INC_SPAN)) ?
                  lfsr_q[8:0] - 9'(2 * class_d_pkg::INC_SPAN) : lfsr_q[8:0];

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      nco_q <= 16'h0000;
      inc_q <= class_d_pkg::INC_LOW;
      lfsr_q <= class_d_pkg::LFSR_SEED;
    end else begin
      nco_q <= nco_sum[15:0];
      lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^
                 lfsr_q[10]};
      case (sync_mode_q)
        class_d_pkg::SYNC_LOW: inc_q <= class_d_pkg::INC_LOW;
        class_d_pkg::SYNC_FLOAT: inc_q <= class_d_pkg::INC_FLOAT;
        class_d_pkg::SYNC_HIGH: begin
          // new random rate only at period start so each cycle is whole
          if (sw_tick) begin
            inc_q <= class_d_pkg::INC_SS - class_d_pkg::INC_SPAN +
                     {7'h00, ss_off};
          end
        end
        default: inc_q <= class_d_pkg::INC_LOW;
      endcase
    end
  end

  // switching period is four oscillator edges
  assign sw_tick = osc_edge && (div_q == 2'(class_d_pkg::SW_DIV - 1));
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      div_q <= 2'h0;
    end else if (osc_edge) begin
      div_q <= div_q + 2'h1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cascade_clock_out <= 1'b1;
    end else if (!power_down_n) begin
      cascade_clock_out <= 1'b1;
    end else if (sync_mode_q == class_d_pkg::SYNC_CLOCKED) begin
      cascade_clock_out <= sync_level;
    end else begin
      cascade_clock_out <= nco_q[15];
    end
  end

  // startup, run, thermal and hard limit sequencing
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= class_d_pkg::ST_OFF;
      start_cnt_q <= '0;
    end else if (!power_down_n) begin
      state_q <= class_d_pkg::ST_OFF;
      start_cnt_q <= '0;
    end else begin
      case (state_q)
        class_d_pkg::ST_OFF: begin
          state_q <= class_d_pkg::ST_START;
          start_cnt_q <= '0;
        end
        class_d_pkg::ST_START: begin
          if (faults.temp_over) begin
            state_q <= class_d_pkg::ST_HOT;
          end else if (start_cnt_q == START_LAST) begin
            state_q <= class_d_pkg::ST_RUN;
          end else begin
            start_cnt_q <= start_cnt_q + 1'b1;
          end
        end
        class_d_pkg::ST_RUN: begin
          if (faults.temp_over) begin
            state_q <= class_d_pkg::ST_HOT;
          end else if (faults.hard_lim) begin
            // repeats for as long as the short stays
            state_q <= class_d_pkg::ST_START;
            start_cnt_q <= '0;
          end
        end
        class_d_pkg::ST_HOT: begin
          if (faults.temp_under) begin
            state_q <= class_d_pkg::ST_RUN;
          end
        end
        default: state_q <= class_d_pkg::ST_OFF;
      endcase
    end
  end

  // registers: reset only by rst_b, so power down keeps them
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      vol_q <= class_d_pkg::VOL_RESET;
      pwm_q <= 1'b0;
    end else if (reg_wr && serial_enable) begin
      if (reg_addr == class_d_pkg::REG_VOLUME &&
          reg_wdata[7:6] == class_d_pkg::VOL_SEL_SPEAKER) begin
        vol_q <= reg_wdata[5:0];
      end
      if (reg_addr == class_d_pkg::REG_MODE) begin
        pwm_q <= reg_wdata[class_d_pkg::MODE_PWM_BIT];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd && reg_addr == class_d_pkg::REG_VOLUME) begin
      reg_rdata <= {2'h0, vol_q};
    end else if (reg_rd && reg_addr == class_d_pkg::REG_MODE) begin
      reg_rdata <= {7'h00, pwm_q};
    end else if (reg_rd && reg_addr == class_d_pkg::REG_STATUS) begin
      reg_rdata <= {1'b0, classic, clip_q, ext_ok_q, 2'(state_q),
                    2'(sync_mode_q)};
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // mute leaves the modulator running and silences only the level
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      volume_level <= 6'h00;
    end else if (mute) begin
      volume_level <= 6'h00;
    end else begin
      volume_level <= serial_enable ? vol_q : vol_analog;
    end
  end

  // modulator timing within one switching period
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pcnt_q <= 8'h00;
      per_q <= 8'h00;
      clip_q <= 1'b0;
    end else begin
      if (sw_tick) begin
        pcnt_q <= 8'h00;
        per_q <= pcnt_q + 8'h01;
      end else if (pcnt_q != 8'hff) begin
        pcnt_q <= pcnt_q + 8'h01;
      end
      // a new overcurrent wins over the period-start release
      clip_q <= faults.soft_lim | (clip_q & ~sw_tick);
    end
  end

  assign classic = serial_enable ? pwm_q : serial_clk_level;
  assign mag = audio_in[7] ? 8'(-audio_in) : 8'(audio_in);
  assign width = {1'b0, mag} >> class_d_pkg::AUDIO_SHIFT;
  assign half = {1'b0, per_q} >> 1;
  assign pc = {1'b0, pcnt_q};
  always_comb begin
    if (classic) begin
      // 50% duty at zero input, outputs complementary
      p_on = audio_in[7] ? (pc + width < half) : (pc < half + width);
      n_on = ~p_on;
    end else begin
      // only the side matching the input sign widens
      p_on = pc < class_d_pkg::MIN_PULSE +
             (audio_in[7] ? 9'h000 : width);
      n_on = pc < class_d_pkg::MIN_PULSE +
             (audio_in[7] ? width : 9'h000);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      amp_drive <= '0;
    end else if (state_q != class_d_pkg::ST_RUN || !power_down_n) begin
      amp_drive <= '0;
    end else begin
      amp_drive.oe <= 1'b1;
      amp_drive.p <= p_on & ~clip_q & ~faults.soft_lim;
      amp_drive.n <= n_on & ~clip_q & ~faults.soft_lim;
    end
  end

  // helper: oscillator edges since the last switching tick
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      since_q <= 3'h0;
    end else if (sw_tick) begin
      since_q <= 3'h0;
    end else if (osc_edge) begin
      since_q <= since_q + 3'h1;
    end
  end

  a_pd_outputs_off: assert property (
    !power_down_n |=> !amp_drive.oe && cascade_clock_out)
    else $error("power down left outputs driven or cascade clock low");
  a_pd_vol_kept: assert property (
    $changed(power_down_n) && !reg_wr |=> $stable(vol_q))
    else $error("volume register changed across power down");
  a_hard_restart: assert property (
    state_q == class_d_pkg::ST_RUN && faults.hard_lim &&
    !faults.temp_over && power_down_n
    |=> state_q == class_d_pkg::ST_START ##1 !amp_drive.oe)
    else $error("hard limit did not restart startup");
  a_temp_off: assert property (
    faults.temp_over && power_down_n && state_q != class_d_pkg::ST_OFF
    |=> state_q == class_d_pkg::ST_HOT ##1 !amp_drive.oe)
    else $error("over temperature did not disable outputs");
  a_temp_hold: assert property (
    state_q == class_d_pkg::ST_HOT && !faults.temp_under && power_down_n
    |=> state_q == class_d_pkg::ST_HOT)
    else $error("thermal shutdown left before cooling");
  a_soft_clip: assert property (
    faults.soft_lim |=> !amp_drive.p && !amp_drive.n)
    else $error("soft limit did not cut the pulse");
  a_mute_live: assert property (
    mute && power_down_n && state_q == class_d_pkg::ST_RUN
    |=> volume_level == 6'h00 && amp_drive.oe)
    else $error("mute stopped switching or left volume up");
  a_div_four: assert property (
    sw_tick |-> since_q == 3'(class_d_pkg::SW_DIV - 1))
    else $error("switching tick not every fourth oscillator edge");
  a_start_hiz: assert property (
    state_q == class_d_pkg::ST_START |=> !amp_drive.oe)
    else $error("outputs active during startup");
endmodule

/* File: hdl/class_d_pkg.sv */
// constants, types and register map for the class d mode and fault control
package class_d_pkg;
  // system clock
  localparam int CLK_KHZ = 10000;
  localparam int CLK_NS = 100;
  // startup sequence lengths
  localparam int STARTUP_MS = 220;
  localparam int STARTUP_FAST_MS = 15;
  localparam int STARTUP_CYC = STARTUP_MS * CLK_KHZ;
  localparam int STARTUP_FAST_CYC = STARTUP_FAST_MS * CLK_KHZ;
  // oscillator rates, switching rate is oscillator / SW_DIV
  localparam int OSC_LOW_KHZ = 1200;
  localparam int OSC_FLOAT_KHZ = 1440;
  localparam int OSC_SS_KHZ = 1200;
  localparam int OSC_SS_SPAN_KHZ = 30;
  localparam int SW_DIV = 4;
  localparam int NCO_W = 16;
  localparam logic [15:0] INC_LOW = 16'(OSC_LOW_KHZ * 65536 / CLK_KHZ);
  localparam logic [15:0] INC_FLOAT = 16'(OSC_FLOAT_KHZ * 65536 / CLK_KHZ);
  localparam logic [15:0] INC_SS = 16'(OSC_SS_KHZ * 65536 / CLK_KHZ);
  localparam logic [15:0] INC_SPAN = 16'(OSC_SS_SPAN_KHZ * 65536 / CLK_KHZ);
  localparam logic [15:0] LFSR_SEED = 16'h0001;
  // external clock detection window
  localparam int EXT_WIN_NS = 10000;
  localparam int EXT_WIN_CYC = EXT_WIN_NS / CLK_NS;
  localparam int EXT_MIN_KHZ = 1000;
  localparam int EXT_MAX_KHZ = 1600;
  localparam logic [4:0] EDGES_MIN = 5'(EXT_MIN_KHZ * EXT_WIN_NS / 1000000);
  localparam logic [4:0] EDGES_MAX = 5'(EXT_MAX_KHZ * EXT_WIN_NS / 1000000);
  localparam logic [4:0] TOGGLE_EDGES = 5'h02;
  // modulator shaping
  localparam logic [8:0] MIN_PULSE = 9'h002;
  localparam int AUDIO_SHIFT = 3;
  // register map
  localparam int ADDR_W = 4;
  localparam logic [3:0] REG_VOLUME = 4'h0;
  localparam logic [3:0] REG_MODE = 4'h1;
  localparam logic [3:0] REG_STATUS = 4'h2;
  localparam logic [1:0] VOL_SEL_SPEAKER = 2'h0;
  localparam int VOL_W = 6;
  localparam logic [5:0] VOL_RESET = 6'h00;
  localparam int MODE_PWM_BIT = 0;
  localparam logic [4:0] SLAVE_BASE = 5'h12;

  typedef enum logic [1:0] {SYNC_LOW, SYNC_FLOAT, SYNC_HIGH, SYNC_CLOCKED}
    sync_mode_t;
  typedef enum logic [1:0] {ST_OFF, ST_START, ST_RUN, ST_HOT} amp_state_t;
  typedef struct packed {
    logic soft_lim;
    logic hard_lim;
    logic temp_over;
    logic temp_under;
  } fault_t;
  typedef struct packed {
    logic p;
    logic n;
    logic oe;
  } drive_t;
endpackage

/* File: dv/sync_host.sv */
// sync pin source: static levels, floating or a clock
`timescale 1ns/1ns
module sync_host (
  input wire logic sys_clk,
  input wire class_d_pkg::sync_mode_t sel,
  input wire logic [3:0] half,
  output logic sync_level,
  output logic sync_floating
);
  logic [3:0] cnt_q;
  logic clk_q;
  initial begin
    cnt_q = 4'h0;
    clk_q = 1'b0;
  end
  // half period in system cycles; 4 and 5 stay in range, 2 is too fast
  always @(posedge sys_clk) begin
    if (cnt_q + 4'h1 >= half) begin
      cnt_q <= 4'h0;
      clk_q <= ~clk_q;
    end else begin
      cnt_q <= cnt_q + 4'h1;
    end
  end
  // steady low while floating, else the sense would see edges
  assign sync_floating = (sel == class_d_pkg::SYNC_FLOAT);
  always_comb begin
    case (sel)
      class_d_pkg::SYNC_HIGH: sync_level = 1'b1;
      class_d_pkg::SYNC_CLOCKED: sync_level = clk_q;
      default: sync_level = 1'b0;
    endcase
  end
endmodule

/* File: dv/tb_top.sv */
// self-checking bench for the class d mode and fault control
`timescale 1ns/1ns
module tb_top;
  typedef struct packed {
    logic [1:0] straps;
    logic en;
    logic [6:0] addr;
  } row_t;
  localparam row_t rows [4] = '{'{2'h0, 1'h0, 7'h48},
    '{2'h1, 1'h1, 7'h49}, '{2'h2, 1'h1, 7'h4a}, '{2'h3, 1'h1, 7'h4b}};
  int c_lo [3] = '{119, 143, 116};
  int c_hi [3] = '{120, 144, 124};
  int p_lo [3] = '{29, 35, 28};
  int p_hi [3] = '{30, 36, 31};
  logic [3:0] hv [3] = '{4'h2, 4'h5, 4'h4};
  logic [7:0] inr [3] = '{8'h00, 8'h01, 8'h01};
  logic sys_clk, rst_b, power_down_n, serial_clk_level, mute, s0, s1;
  logic sync_level, sync_floating, reg_wr, reg_rd;
  logic cascade_clock_out, serial_enable;
  logic [5:0] vol_analog, volume_level;
  logic [3:0] reg_addr, half;
  logic [7:0] reg_wdata, reg_rdata, d;
  logic signed [7:0] audio_in;
  logic [6:0] slave_addr;
  class_d_pkg::fault_t faults;
  class_d_pkg::drive_t amp_drive;
  class_d_pkg::sync_mode_t sel;
  int miscompares, comparisons, kc, kp, hp, hn, hz;

  // fast count differs so a wrong variant pick shows in startup timing
  class_d_ctrl #(.STARTUP_CYCLES(50), .STARTUP_FAST_CYCLES(30))
    class_d_ctrl_i (.sys_clk, .rst_b, .power_down_n, .sync_level,
    .sync_floating, .serial_clk_level, .slave_id_strap_0(s0),
    .slave_id_strap_1(s1), .mute, .vol_analog, .audio_in, .faults,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .amp_drive,
    .cascade_clock_out, .volume_level, .serial_enable, .slave_addr);
  sync_host sync_host_i (.sys_clk, .sel, .half, .sync_level,
    .sync_floating);

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp,
    input string msg);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t ns: %s", $time, msg);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // rises of cascade and p, high cycles of p and n
  task automatic span(input int n);
    logic pc, pp;
    kc = 0;
    kp = 0;
    hp = 0;
    hn = 0;
    pc = cascade_clock_out;
    pp = amp_drive.p;
    repeat (n) begin
      @(negedge sys_clk);
      if (cascade_clock_out && !pc) kc++;
      if (amp_drive.p && !pp) kp++;
      if (amp_drive.p) hp++;
      if (amp_drive.n) hn++;
      pc = cascade_clock_out;
      pp = amp_drive.p;
    end
  endtask
  task automatic close_out;
    $display("compares %0d, mismatches %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // whole run is near 9100 cycles, so 20000 means a hang
  initial begin
    #2000000;
    miscompares++;
    $display("wrong value at %0t ns: run timed out", $time);
    close_out();
  end

  initial begin
    miscompares = 0;
    comparisons = 0;
    rst_b = 1'b0;
    power_down_n = 1'b0;
    serial_clk_level = 1'b0;
    mute = 1'b0;
    s0 = 1'b0;
    s1 = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    vol_analog = 6'h00;
    audio_in = 8'h00;
    half = 4'h4;
    sel = class_d_pkg::SYNC_LOW;
    faults = 4'h0;
    cyc(3);
    chk(amp_drive, 8'h00, "drive in reset");
    chk(volume_level, 8'h00, "volume in reset");
    rst_b <= 1'b1;
    cyc(10);
    chk(amp_drive.oe, 8'h00, "oe in power down");
    chk(cascade_clock_out, 8'h01, "cascade in power down");
    power_down_n <= 1'b1;
    cyc(40);
    chk(amp_drive.oe, 8'h00, "oe early in startup");
    cyc(20);
    chk(amp_drive.oe, 8'h01, "oe after startup");
    foreach (rows[i]) begin
      {s1, s0} <= rows[i].straps;
      cyc(1);
      chk(serial_enable, rows[i].en, "serial enable");
      chk(slave_addr, rows[i].addr, "slave address");
    end
    $display("test startup and straps done");
    wr(class_d_pkg::REG_VOLUME, 8'h2a);
    cyc(2);
    chk(volume_level, 8'h2a, "volume write");
    rd(class_d_pkg::REG_VOLUME);
    chk(d, 8'h2a, "volume read");
    wr(class_d_pkg::REG_VOLUME, 8'h45);
    cyc(2);
    chk(volume_level, 8'h2a, "other selector");
    mute <= 1'b1;
    cyc(2);
    chk(volume_level, 8'h00, "muted volume");
    chk(amp_drive.oe, 8'h01, "on while muted");
    mute <= 1'b0;
    rd(4'h7);
    chk(d, 8'h00, "unmapped read");
    power_down_n <= 1'b0;
    cyc(3);
    chk(amp_drive.oe, 8'h00, "oe in shutdown");
    chk(cascade_clock_out, 8'h01, "cascade in shutdown");
    wr(class_d_pkg::REG_MODE, 8'h01);
    power_down_n <= 1'b1;
    cyc(60);
    chk(volume_level, 8'h2a, "volume kept");
    rd(class_d_pkg::REG_STATUS);
    chk(d[6], 8'h01, "scheme from register");
    $display("test serial volume done");
    {s1, s0} <= 2'h0;
    vol_analog <= 6'h11;
    cyc(3);
    chk(volume_level, 8'h11, "analog volume");
    wr(class_d_pkg::REG_VOLUME, 8'h05);
    cyc(2);
    chk(volume_level, 8'h11, "write in analog mode");
    rd(class_d_pkg::REG_STATUS);
    chk(d[6], 8'h00, "filterless by clock pin");
    serial_clk_level <= 1'b1;
    rd(class_d_pkg::REG_STATUS);
    chk(d[6], 8'h01, "classic by clock pin");
    for (int m = 0; m < 3; m++) begin
      sel <= class_d_pkg::sync_mode_t'(m);
      cyc(250);
      rd(class_d_pkg::REG_STATUS);
      chk(d[1:0], 8'(m), "sync decode");
      span(1000);
      chk(kc >= c_lo[m] && kc <= c_hi[m], 8'h01, "osc rate");
      chk(kp >= p_lo[m] && kp <= p_hi[m], 8'h01, "sw rate");
    end
    sel <= class_d_pkg::SYNC_CLOCKED;
    for (int i = 0; i < 3; i++) begin
      half <= hv[i];
      cyc(250);
      rd(class_d_pkg::REG_STATUS);
      chk(d[1:0], 8'h03, "clocked decode");
      chk(d[4], inr[i], "clock range");
    end
    span(800);
    chk(8'(kc), 8'h64, "cascade rate");
    chk(8'(kp), 8'h19, "quarter rate");
    $display("test modes done");
    sel <= class_d_pkg::SYNC_LOW;
    serial_clk_level <= 1'b0;
    cyc(250);
    span(1000);
    chk(hp - hn <= 2 && hn - hp <= 2, 8'h01, "equal pulses");
    hz = hn;
    audio_in <= 8'h40;
    cyc(40);
    span(1000);
    chk(hp > hn + 100, 8'h01, "positive side widens");
    chk(hn - hz <= 2 && hz - hn <= 2, 8'h01, "n side kept");
    audio_in <= 8'hc0;
    cyc(40);
    span(1000);
    chk(hn > hp + 100, 8'h01, "negative side widens");
    chk(hp - hz <= 2 && hz - hp <= 2, 8'h01, "p side kept");
    audio_in <= 8'h00;
    faults.soft_lim <= 1'b1;
    cyc(2);
    chk({amp_drive.p, amp_drive.n}, 8'h00, "soft cut");
    rd(class_d_pkg::REG_STATUS);
    chk(d[5], 8'h01, "soft clip on");
    faults.soft_lim <= 1'b0;
    cyc(200);
    rd(class_d_pkg::REG_STATUS);
    chk(d[5], 8'h00, "soft clip off");
    faults.hard_lim <= 1'b1;
    cyc(1);
    faults.hard_lim <= 1'b0;
    cyc(3);
    chk(amp_drive.oe, 8'h00, "hard limit off");
    rd(class_d_pkg::REG_STATUS);
    chk(d[3:2], 8'h01, "restart");
    cyc(60);
    chk(amp_drive.oe, 8'h01, "back after restart");
    faults.temp_over <= 1'b1;
    cyc(3);
    chk(amp_drive.oe, 8'h00, "hot off");
    faults.temp_over <= 1'b0;
    cyc(20);
    rd(class_d_pkg::REG_STATUS);
    chk(d[3:2], 8'h03, "off until cooled");
    faults.temp_under <= 1'b1;
    cyc(3);
    chk(amp_drive.oe, 8'h01, "cooled on");
    $display("test faults done");
    close_out();
  end
endmodule
